//--- msd_cfg.svh
// constants for the memory space decode and external bus block
// assumes a 125 MHz core clock; included by bare name where needed
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH

// ----------------------------------------------------------------
// clock and bus timing
// ----------------------------------------------------------------
`define MSD_CLK_NS        8
`define MSD_ALE_NS        16
`define MSD_STRB_NS       40
`define MSD_ALE_CYC       ((`MSD_ALE_NS + `MSD_CLK_NS - 1) / `MSD_CLK_NS)
`define MSD_STRB_CYC      ((`MSD_STRB_NS + `MSD_CLK_NS - 1) / `MSD_CLK_NS)
`define MSD_CNT_W         4

// ----------------------------------------------------------------
// program space
// ----------------------------------------------------------------
`define MSD_APP_FLASH_SIZE 17'h08000
`define MSD_LDR_FLASH_SIZE 17'h01000
`define MSD_TABLE_BLOCKED  8'h00

// ----------------------------------------------------------------
// data spaces
// ----------------------------------------------------------------
`define MSD_AUX_TOP       16'h03ff
`define MSD_AUX_AW        10
`define MSD_AUX_WORDS     1024
`define MSD_DIRECT_TOP    8'h7f
`define MSD_BITRAM_BASE   8'h20
`define MSD_BITRAM_END    8'h30
`define MSD_BANK_LO_BIT   3
`define MSD_BANK_HI_BIT   4
`define MSD_SP_RST        8'h07
`define MSD_P0_FILL       8'hff

`endif

//--- msd_dec_if.sv
// carrier between the top and the internal data address decoder
// assumes msd_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none
interface msd_dec_if;
   logic                addr_valid;
   logic [7:0]          addr;
   logic                indirect;
   logic                bit_op;
   logic                reg_op;
   logic [2:0]          reg_num;
   logic [1:0]          bank;
   msd_pkg::msd_dsel_e  sel;
   logic [7:0]          byte_addr;
   logic [2:0]          bit_pos;
   logic                bit_capable;

   modport req (output addr_valid, addr, indirect, bit_op, reg_op, reg_num, bank,
                input  sel, byte_addr, bit_pos, bit_capable);
   modport dec (input  addr_valid, addr, indirect, bit_op, reg_op, reg_num, bank,
                output sel, byte_addr, bit_pos, bit_capable);
endinterface
`default_nettype wire

//--- msd_ext_mem.sv
// external program and data memory with its address latch
// assumes the bus sequence of msd_top; lat holds data back in strobe cycles
`timescale 1ns/1ps
`default_nettype none
module msd_ext_mem (
   input wire logic       ref_clk, ale, code_fetch_strobe_n,
   input wire logic [7:0] p0_out, p2_out,
   input wire logic [1:0] p3_hi_out,
   input wire logic [2:0] lat,
   output logic     [7:0] p0_in
);
   logic [7:0]  mem [logic [15:0]];
   logic [15:0] a = 16'h0000;
   logic [7:0]  last = 8'h00;
   logic [2:0]  n = 3'h0;
   logic        rd;
   assign rd = !code_fetch_strobe_n || !p3_hi_out[1];
   always @(negedge ale) a = {p2_out, p0_out};
   always @(posedge p3_hi_out[0]) mem[a] = p0_out;
   // port 0 has no pull-ups, so an undriven bus shows a toggling pattern
   always @(posedge ref_clk) n <= rd ? n + 3'(n != 3'h7) : 3'h0;
   always @(posedge ref_clk) last <= p0_in;
   always @* p0_in = (rd && n >= lat) ? (mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8]) : ~last;
endmodule
`default_nettype wire

//--- msd_idecode.sv
// internal data address decoder: banks, bit space, upper ram, function regs
// assumes a purely combinational use; the top passes the result straight to its ports
`timescale 1ns/1ps
`default_nettype none
`include "msd_cfg.svh"
module msd_idecode (
   // decode request and result
   msd_dec_if.dec d
);
   import msd_pkg::*;

   // byte direct or indirect address to a space
   function automatic msd_dsel_e byte_space(input logic [7:0] a, input logic ind);
      if (a <= `MSD_DIRECT_TOP) begin
         byte_space = MSD_DS_LOW;
      end else begin
         byte_space = ind ? MSD_DS_UPPER : MSD_DS_SFR;
      end
   endfunction

   // only function regs at x0h or x8h take single-bit access
   function automatic logic bit_ok(input logic [7:0] a);
      bit_ok = (a[2:0] == 3'h0);
   endfunction

   always_comb begin
      d.sel         = MSD_DS_LOW;
      d.byte_addr   = d.addr;
      d.bit_pos     = 3'h0;
      d.bit_capable = 1'b0;
      if (d.addr_valid && d.reg_op) begin
         d.byte_addr = {3'h0, d.bank, d.reg_num};
      end else if (d.addr_valid && d.bit_op && !d.addr[7]) begin
         d.byte_addr   = `MSD_BITRAM_BASE + {4'h0, d.addr[6:3]};
         d.bit_pos     = d.addr[2:0];
         d.bit_capable = 1'b1;
      end else if (d.addr_valid && d.bit_op) begin
         d.sel         = MSD_DS_SFR;
         d.byte_addr   = {d.addr[7:3], 3'h0};
         d.bit_pos     = d.addr[2:0];
         d.bit_capable = 1'b1;
      end else if (d.addr_valid) begin
         d.sel         = byte_space(d.addr, d.indirect);
         d.bit_capable = (d.sel == MSD_DS_LOW && d.addr >= `MSD_BITRAM_BASE
                          && d.addr < `MSD_BITRAM_END)
                         || (d.sel == MSD_DS_SFR && bit_ok(d.addr));
      end
   end
endmodule
`default_nettype wire

//--- msd_pkg.sv
// types shared by the memory space decode and external bus block
// assumes msd_cfg.svh constants; no logic here
package msd_pkg;

   // bus sequencer states, gray along idle-ale-latch-strobe-release
   typedef enum logic [2:0] {
      MSD_IDLE = 3'b000,
      MSD_ALE  = 3'b001,
      MSD_LAT  = 3'b011,
      MSD_STRB = 3'b010,
      MSD_RLS  = 3'b110
   } msd_bus_e;

   // kinds of core access
   typedef enum logic [1:0] {
      MSD_ACC_FETCH = 2'h0,
      MSD_ACC_TABLE = 2'h1,
      MSD_ACC_XRD   = 2'h2,
      MSD_ACC_XWR   = 2'h3
   } msd_acc_e;

   // internal data space target
   typedef enum logic [1:0] {
      MSD_DS_LOW   = 2'h0,
      MSD_DS_UPPER = 2'h1,
      MSD_DS_SFR   = 2'h2
   } msd_dsel_e;

   // power-on strap holder
   typedef struct packed {
      logic seen;
      logic ext_all;
   } msd_strap_s;

   // whole sequencer state of the top
   typedef struct packed {
      msd_bus_e  st;
      logic [3:0] cnt;
      logic       code_strb;
      logic       is_write;
      logic       wide;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic       done;
      logic       blocked;
      logic       ext_exec;
      logic       isp_ok;
      logic [7:0] sp;
      logic       int_pend;
      logic       int_wait;
      logic       int_aux;
      logic       int_we;
      logic       p0_fill;
   } msd_state_s;

endpackage

//--- msd_ram.sv
// single port byte memory for the on-chip auxiliary data space
// assumes one access per cycle; read data come from a register
`timescale 1ns/1ps
`default_nettype none
`include "msd_cfg.svh"
module msd_ram (
   // clock
   input  wire logic                   ref_clk,
   // access
   input  wire logic                   en,
   input  wire logic                   we,
   input  wire logic [`MSD_AUX_AW-1:0] addr,
   input  wire logic [7:0]             wdata,
   output logic      [7:0]             rdata
);
   logic [7:0] mem_r [0:`MSD_AUX_WORDS-1];

   // no reset: contents are undefined after power-up, like the real array
   always_ff @(posedge ref_clk) begin
      if (en && we) begin
         mem_r[addr] <= wdata;
      end
      if (en && !we) begin
         rdata <= mem_r[addr];
      end
   end
endmodule
`default_nettype wire

//--- msd_top.sv
// memory space decode and external memory bus of the core
// assumes the core issues one access at a time and waits for acc_done;
// internal flash answers the cycle after iflash_rd
`timescale 1ns/1ps
`default_nettype none
`include "msd_cfg.svh"

module msd_top (
   // clock and resets
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                por,
   // straps and configuration
   input  wire logic                code_source_select_n,
   input  wire logic                code_read_lock,
   input  wire logic                aux_onchip_ram_on,
   input  wire logic                run_from_loader,
   // core access request
   input  wire logic                acc_req,
   input  wire msd_pkg::msd_acc_e   acc_kind,
   input  wire logic                acc_wide,
   input  wire logic [15:0]         acc_addr,
   input  wire logic [7:0]          acc_wdata,
   output logic                     acc_ready,
   output logic                     acc_done,
   output logic                     acc_blocked,
   output logic [7:0]               acc_rdata,
   // status
   output logic                     exec_external,
   output logic                     isp_allowed,
   output logic                     p0_latch_fill,
   // internal code flash
   output logic                     iflash_rd,
   output logic [15:0]              iflash_addr,
   input  wire logic [7:0]          iflash_rdata,
   // stack pointer
   input  wire logic                sp_push,
   input  wire logic                sp_pop,
   input  wire logic                sp_load,
   input  wire logic [7:0]          sp_wdata,
   output logic [7:0]               stack_top_pointer,
   output logic [7:0]               stack_addr,
   // internal data address decode
   input  wire logic                id_valid,
   input  wire logic [7:0]          id_addr,
   input  wire logic                id_indirect,
   input  wire logic                id_bit,
   input  wire logic                id_reg,
   input  wire logic [2:0]          id_reg_num,
   input  wire logic [7:0]          flags_word,
   output msd_pkg::msd_dsel_e       id_sel,
   output logic [7:0]               id_byte_addr,
   output logic [2:0]               id_bit_pos,
   output logic                     id_bit_capable,
   // general i/o requests for the shared pins
   input  wire logic [7:0]          gpio_p0_out,
   input  wire logic [7:0]          gpio_p0_oe,
   input  wire logic [7:0]          gpio_p2_out,
   input  wire logic [7:0]          gpio_p2_oe,
   input  wire logic [1:0]          gpio_p3_hi_out,
   input  wire logic [1:0]          gpio_p3_hi_oe,
   // external bus pins
   input  wire logic [7:0]          p0_in,
   output logic [7:0]               p0_out,
   output logic [7:0]               p0_oe,
   output logic [7:0]               p2_out,
   output logic [7:0]               p2_oe,
   output logic [1:0]               p3_hi_out,
   output logic [1:0]               p3_hi_oe,
   output logic                     ale,
   output logic                     code_fetch_strobe_n,
   output logic                     bus_active
);
   import msd_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   msd_state_s state_r;
   msd_state_s state_nxt;
   msd_strap_s strap_r;
   msd_strap_s strap_nxt;
   logic [7:0] aux_rdata;
   logic       route_ext;
   logic       int_target;

   msd_dec_if  dec ();

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // code address lies past the active internal flash
   function automatic logic past_flash(input logic [15:0] a, input logic ldr);
      past_flash = ({1'b0, a} >= (ldr ? `MSD_LDR_FLASH_SIZE : `MSD_APP_FLASH_SIZE));
   endfunction

   // external data address falls in the on-chip auxiliary window
   function automatic logic in_aux(input logic [15:0] a, input logic on);
      in_aux = on && (a <= `MSD_AUX_TOP);
   endfunction

   // ----------------------------------------------------------------
   // power-on strap
   // ----------------------------------------------------------------

   // caught once after power-on only; the system reset leaves it alone
   always_comb begin
      strap_nxt = strap_r;
      if (!strap_r.seen) begin
         strap_nxt.seen    = 1'b1;
         strap_nxt.ext_all = !code_source_select_n;
      end
   end

   always_ff @(posedge ref_clk or posedge por) begin
      if (por) begin
         strap_r <= '0;
      end else begin
         strap_r <= strap_nxt;
      end
   end

   // ----------------------------------------------------------------
   // routing of a new request
   // ----------------------------------------------------------------

   // code goes out for every address on ext_all, else past the flash size
   always_comb begin
      route_ext  = 1'b0;
      int_target = 1'b0;
      unique case (acc_kind)
         MSD_ACC_FETCH, MSD_ACC_TABLE: begin
            route_ext = strap_r.ext_all
                        || past_flash(acc_addr, run_from_loader);
         end
         MSD_ACC_XRD, MSD_ACC_XWR: begin
            int_target = in_aux(acc_addr, aux_onchip_ram_on);
            route_ext  = !int_target;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------

   // one access at a time; the bus walk is ale, latch, strobe, release
   always_comb begin
      state_nxt          = state_r;
      state_nxt.done     = 1'b0;
      state_nxt.blocked  = 1'b0;
      state_nxt.p0_fill  = 1'b0;
      state_nxt.int_pend = 1'b0;
      state_nxt.isp_ok   = !state_r.ext_exec && !strap_r.ext_all;

      // stack pointer: push pre-increments, pop post-decrements
      if (sp_load) begin
         state_nxt.sp = sp_wdata;
      end else if (sp_push) begin
         state_nxt.sp = state_r.sp + 8'h01;
      end else if (sp_pop) begin
         state_nxt.sp = state_r.sp - 8'h01;
      end

      // internal flash or aux ram answers one cycle after the strobe
      state_nxt.int_wait = state_r.int_pend;
      if (state_r.int_wait) begin
         state_nxt.rdata = state_r.int_aux ? aux_rdata : iflash_rdata;
         state_nxt.done  = 1'b1;
      end

      unique case (state_r.st)
         MSD_IDLE: begin
            if (acc_req && acc_ready) begin
               state_nxt.addr      = acc_addr;
               state_nxt.wdata     = acc_wdata;
               state_nxt.is_write  = (acc_kind == MSD_ACC_XWR);
               state_nxt.code_strb = (acc_kind == MSD_ACC_FETCH)
                                     || (acc_kind == MSD_ACC_TABLE);
               state_nxt.wide      = acc_wide || state_nxt.code_strb;
               state_nxt.int_aux   = int_target;
               state_nxt.int_we    = (acc_kind == MSD_ACC_XWR);
               if (acc_kind == MSD_ACC_FETCH) begin
                  state_nxt.ext_exec = route_ext;
               end
               if (acc_kind == MSD_ACC_TABLE && !route_ext && !code_read_lock
                   && state_r.ext_exec) begin
                  state_nxt.rdata   = `MSD_TABLE_BLOCKED;
                  state_nxt.blocked = 1'b1;
                  state_nxt.done    = 1'b1;
               end else if (route_ext) begin
                  state_nxt.st      = MSD_ALE;
                  state_nxt.cnt     = 4'(`MSD_ALE_CYC - 1);
                  state_nxt.p0_fill = 1'b1;
               end else begin
                  state_nxt.int_pend = 1'b1;
               end
            end
         end
         MSD_ALE: begin
            // last cycle here holds the address on port 0 with ale already low
            if (state_r.cnt == 4'h0) begin
               state_nxt.st = MSD_LAT;
            end else begin
               state_nxt.cnt = state_r.cnt - 4'h1;
            end
         end
         MSD_LAT: begin
            state_nxt.st  = MSD_STRB;
            state_nxt.cnt = 4'(`MSD_STRB_CYC - 1);
         end
         MSD_STRB: begin
            if (state_r.cnt == 4'h0) begin
               state_nxt.st = MSD_RLS;
               if (!state_r.is_write) begin
                  state_nxt.rdata = p0_in;
               end
            end else begin
               state_nxt.cnt = state_r.cnt - 4'h1;
            end
         end
         MSD_RLS: begin
            state_nxt.st   = MSD_IDLE;
            state_nxt.done = 1'b1;
         end
         default: begin
            state_nxt.st = MSD_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r    <= '0;
         state_r.sp <= `MSD_SP_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------

   // pins belong to the bus only between ale and release
   always_comb begin
      bus_active          = (state_r.st != MSD_IDLE);
      p0_out              = gpio_p0_out;
      p0_oe               = gpio_p0_oe;
      p2_out              = gpio_p2_out;
      p2_oe               = gpio_p2_oe;
      p3_hi_out           = gpio_p3_hi_out;
      p3_hi_oe            = gpio_p3_hi_oe;
      ale                 = 1'b0;
      code_fetch_strobe_n = 1'b1;
      if (bus_active) begin
         // high address on port 2 only for 16-bit or code accesses
         if (state_r.wide) begin
            p2_out = state_r.addr[15:8];
            p2_oe  = 8'hff;
         end
         // read/write strobes take p3.7 and p3.6 for data cycles
         if (!state_r.code_strb) begin
            p3_hi_oe  = 2'h3;
            p3_hi_out = 2'h3;
         end
         p0_out = state_r.addr[7:0];
         p0_oe  = 8'hff;
         // ale drops for the last ale-state cycle so the address outlasts its
         // falling edge; needs MSD_ALE_CYC of 2 or more
         ale    = (state_r.st == MSD_ALE) && (state_r.cnt != 4'h0);
         if (state_r.st == MSD_STRB || state_r.st == MSD_RLS
             || state_r.st == MSD_LAT) begin
            // write data ahead of the strobe and past its release
            p0_out = state_r.wdata;
            p0_oe  = state_r.is_write ? 8'hff : 8'h00;
         end
         if (state_r.st == MSD_STRB) begin
            if (state_r.code_strb) begin
               code_fetch_strobe_n = 1'b0;
            end else if (state_r.is_write) begin
               p3_hi_out = 2'h2;
            end else begin
               p3_hi_out = 2'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs and sub-blocks
   // ----------------------------------------------------------------

   // ready drops for the whole access so the core never overlaps two
   assign acc_ready         = (state_r.st == MSD_IDLE) && !state_r.int_pend
                              && !state_r.int_wait && strap_r.seen;
   assign acc_done          = state_r.done;
   assign acc_blocked       = state_r.blocked;
   assign acc_rdata         = state_r.rdata;
   assign exec_external     = state_r.ext_exec;
   assign isp_allowed       = state_r.isp_ok;
   assign p0_latch_fill     = state_r.p0_fill;
   assign iflash_rd         = state_r.int_pend && !state_r.int_aux;
   assign iflash_addr       = state_r.addr;
   assign stack_top_pointer = state_r.sp;
   assign stack_addr        = sp_push ? state_r.sp + 8'h01 : state_r.sp;

   // aux ram sees only the low ten address bits of its own window
   msd_ram u_aux (
      .ref_clk (ref_clk),
      .en      (state_r.int_pend && state_r.int_aux),
      .we      (state_r.int_we),
      .addr    (state_r.addr[`MSD_AUX_AW-1:0]),
      .wdata   (state_r.wdata),
      .rdata   (aux_rdata)
   );

   // internal data decode request
   assign dec.addr_valid = id_valid;
   assign dec.addr       = id_addr;
   assign dec.indirect   = id_indirect;
   assign dec.bit_op     = id_bit;
   assign dec.reg_op     = id_reg;
   assign dec.reg_num    = id_reg_num;
   assign dec.bank       = {flags_word[`MSD_BANK_HI_BIT],
                            flags_word[`MSD_BANK_LO_BIT]};
   assign id_sel         = dec.sel;
   assign id_byte_addr   = dec.byte_addr;
   assign id_bit_pos     = dec.bit_pos;
   assign id_bit_capable = dec.bit_capable;

   msd_idecode u_dec (
      .d (dec)
   );
endmodule
`default_nettype wire

//--- msd_top_chk.sv
// assertions on msd_top ports: stack pointer, bus strobes, status
// assumes one clock ref_clk and active high rst; bound after the module
`timescale 1ns/1ps
`default_nettype none
module msd_top_chk (
   input wire logic       ref_clk, rst, sp_push, sp_pop, sp_load, bus_active, ale,
   input wire logic       p0_latch_fill, code_fetch_strobe_n, exec_external, isp_allowed,
   input wire logic [7:0] sp_wdata, stack_top_pointer, stack_addr, p0_oe, p0_out,
   input wire logic [1:0] p3_hi_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // end of the ale pulse, the edge the outside latch uses
   sequence s_ale_end; ale ##1 !ale; endsequence
   property p_push; sp_push && !sp_load |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01;
   endproperty
   property p_pop; sp_pop && !sp_push && !sp_load |=>
      stack_top_pointer == $past(stack_top_pointer) - 8'h01; endproperty
   property p_load; sp_load |=> stack_top_pointer == $past(sp_wdata); endproperty
   property p_stk; sp_push |-> stack_addr == stack_top_pointer + 8'h01; endproperty
   property p_fill; $rose(bus_active) |-> p0_latch_fill; endproperty
   property p_ale; s_ale_end |-> p0_oe == 8'hff && $stable(p0_out); endproperty
   property p_cfs; !code_fetch_strobe_n |-> bus_active && p3_hi_out == 2'b11; endproperty
   property p_isp; exec_external |=> !isp_allowed; endproperty
   a_push: assert property (p_push) else $error("push step wrong");
   a_pop: assert property (p_pop) else $error("pop step wrong");
   a_load: assert property (p_load) else $error("load wrong");
   a_stk: assert property (p_stk) else $error("push address wrong");
   a_fill: assert property (p_fill) else $error("port 0 fill missing");
   a_ale: assert property (p_ale) else $error("address not on port 0");
   a_cfs: assert property (p_cfs) else $error("code strobe outside cycle");
   a_isp: assert property (p_isp) else $error("isp left on");
endmodule
bind msd_top msd_top_chk u_chk (.ref_clk, .rst, .sp_push, .sp_pop, .sp_load, .bus_active, .ale,
   .p0_latch_fill, .code_fetch_strobe_n, .exec_external, .isp_allowed, .sp_wdata,
   .stack_top_pointer, .stack_addr, .p0_oe, .p0_out, .p3_hi_out);
`default_nettype wire

//--- msd_top_tb.sv
// self-checking bench for msd_top with the external memory model
// assumes the design sources and msd_pkg are compiled first
`timescale 1ns/1ps
`default_nettype none
module msd_top_tb;
   import msd_pkg::*;
   logic ref_clk, rst, por, code_source_select_n, code_read_lock, aux_onchip_ram_on, acc_req;
   logic run_from_loader, acc_wide, acc_ready, acc_done, acc_blocked, exec_external, isp_allowed;
   logic p0_latch_fill, iflash_rd, sp_push, sp_pop, sp_load, id_valid, id_indirect, id_bit, ale;
   logic id_reg, code_fetch_strobe_n, bus_active, id_bit_capable;
   msd_acc_e acc_kind;
   msd_dsel_e id_sel;
   logic [15:0] acc_addr, iflash_addr;
   logic [7:0] acc_wdata, acc_rdata, iflash_rdata, sp_wdata, stack_top_pointer, stack_addr, p0_in;
   logic [7:0] id_addr, flags_word, id_byte_addr, gpio_p0_out, gpio_p0_oe, gpio_p2_out, gpio_p2_oe;
   logic [7:0] p0_out, p0_oe, p2_out, p2_oe;
   logic [2:0] id_reg_num, id_bit_pos, lat;
   logic [1:0] gpio_p3_hi_out, gpio_p3_hi_oe, p3_hi_out, p3_hi_oe;
   int errors = 0;
   int n_tests = 0;
   msd_top u_dut (.*);
   msd_ext_mem u_mem (.ref_clk, .ale, .code_fetch_strobe_n, .p0_out, .p2_out, .p3_hi_out, .lat,
      .p0_in);
   // internal flash answers a pattern of its address
   assign iflash_rdata = iflash_addr[7:0] ^ 8'h3c;
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic conclude();
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one core access; waits for completion on falling edges so flags are settled
   task automatic acc(input msd_acc_e k, input logic w, input logic [15:0] a,
                      input logic [7:0] d, e, input logic b);
      int i;
      acc_req <= 1'b1; acc_kind <= k; acc_wide <= w; acc_addr <= a; acc_wdata <= d;
      @(posedge ref_clk);
      acc_req <= 1'b0;
      for (i = 0; i < 20 && acc_done !== 1'b1; i++) @(negedge ref_clk);
      chk("acc_done", acc_done, 1'b1);
      if (k != MSD_ACC_XWR) chk("acc_rdata", acc_rdata, e);
      chk("acc_blocked", acc_blocked, b);
      chk("acc_ready", acc_ready, 1'b1);
      @(posedge ref_clk);
   endtask
   task automatic dec(input logic [7:0] a, input logic i, b, input logic [15:0] e);
      id_addr <= a; id_indirect <= i; id_bit <= b;
      @(negedge ref_clk);
      chk("id_decode", b ? {id_byte_addr, 5'h00, id_bit_pos} : {13'h0000, id_bit_capable, id_sel}, e);
      @(posedge ref_clk);
   endtask
   initial begin
      rst = 1; por = 1; code_source_select_n = 1; code_read_lock = 0; aux_onchip_ram_on = 0;
      run_from_loader = 0; acc_req = 0; acc_kind = MSD_ACC_FETCH; acc_wide = 1; acc_addr = 0;
      acc_wdata = 0; sp_push = 0; sp_pop = 0; sp_load = 0; sp_wdata = 0; id_valid = 1; id_addr = 0;
      id_indirect = 0; id_bit = 0; id_reg = 0; id_reg_num = 0; flags_word = 0; lat = 0;
      gpio_p0_out = 0; gpio_p0_oe = 0; gpio_p2_out = 0; gpio_p2_oe = 0; gpio_p3_hi_out = 3;
      gpio_p3_hi_oe = 0;
      repeat (4) @(posedge ref_clk);
      rst <= 0; por <= 0;
      repeat (2) @(posedge ref_clk);
      code_source_select_n <= 1'b0;
      chk("stack_top_pointer", stack_top_pointer, 8'h07);
      acc(MSD_ACC_FETCH, 1, 16'h7fff, 0, 8'hc3, 0);
      acc(MSD_ACC_FETCH, 1, 16'h8010, 0, 8'h90, 0);
      @(negedge ref_clk);
      chk("isp_allowed", {exec_external, isp_allowed}, 2'b10);
      @(posedge ref_clk);
      acc(MSD_ACC_TABLE, 1, 16'h0040, 0, 8'h00, 1);
      code_read_lock <= 1'b1;
      acc(MSD_ACC_TABLE, 1, 16'h0040, 0, 8'h7c, 0);
      lat <= 3'h4;
      acc(MSD_ACC_XWR, 1, 16'h1234, 8'ha5, 0, 0);
      acc(MSD_ACC_XRD, 1, 16'h1234, 0, 8'ha5, 0);
      acc(MSD_ACC_XWR, 0, 16'h7756, 8'h6e, 0, 0);
      acc(MSD_ACC_XRD, 0, 16'h9956, 0, 8'h6e, 0);
      aux_onchip_ram_on <= 1'b1;
      acc(MSD_ACC_XWR, 1, 16'h03ff, 8'h5e, 0, 0);
      acc(MSD_ACC_XRD, 1, 16'h03ff, 0, 8'h5e, 0);
      aux_onchip_ram_on <= 1'b0;
      acc(MSD_ACC_XRD, 1, 16'h03ff, 0, 8'hfc, 0);
      $display("bus tests done");
      sp_load <= 1; sp_wdata <= 8'hff;
      @(posedge ref_clk);
      sp_load <= 0; sp_push <= 1;
      @(negedge ref_clk);
      chk("stack_addr", stack_addr, 8'h00);
      @(posedge ref_clk);
      sp_push <= 0; sp_pop <= 1;
      @(posedge ref_clk);
      sp_pop <= 0;
      @(negedge ref_clk);
      chk("stack_top_pointer", stack_top_pointer, 8'hff);
      @(posedge ref_clk);
      id_reg <= 1; id_reg_num <= 3'h5;
      for (int b = 0; b < 4; b++) begin
         flags_word <= {3'h0, 2'(b), 3'h0};
         @(negedge ref_clk);
         chk("id_byte_addr", id_byte_addr, {3'h0, 2'(b), 3'h5});
         @(posedge ref_clk);
      end
      id_reg <= 0;
      dec(8'h90, 0, 0, 16'h0006);
      dec(8'h90, 1, 0, 16'h0001);
      dec(8'h45, 0, 0, 16'h0000);
      dec(8'h45, 1, 0, 16'h0000);
      dec(8'h0a, 0, 1, 16'h2102);
      dec(8'h7f, 0, 1, 16'h2f07);
      dec(8'h2a, 0, 0, 16'h0004);
      dec(8'h93, 0, 1, 16'h9003);
      $display("stack and decode tests done");
      por <= 1;
      repeat (2) @(posedge ref_clk);
      por <= 0;
      repeat (2) @(posedge ref_clk);
      acc(MSD_ACC_FETCH, 1, 16'h0100, 0, 8'h01, 0);
      $display("strap test done");
      conclude();
   end
   // cut a hang short well past the 120 or so cycles the tests need
   initial begin
      repeat (4000) @(posedge ref_clk);
      errors++;
      conclude();
   end
endmodule
`default_nettype wire
